// ---- src/bct_pkg.sv ----
package bct_pkg;
    // Register word offsets (byte address = index * 4)
    localparam logic [5:0] IDX_AUX_CONTROL   = 6'h04;
    localparam logic [5:0] IDX_IRQ_STATUS    = 6'h05;
    localparam logic [5:0] IDX_PRELOAD_HIGH  = 6'h06;
    localparam logic [5:0] IDX_PRELOAD_LOW   = 6'h07;
    localparam logic [5:0] IDX_START         = 6'h0E;
    localparam logic [5:0] IDX_STOP          = 6'h0F;
    localparam logic [5:0] IDX_CMD_A         = 6'h02;
    localparam logic [5:0] IDX_CMD_B         = 6'h0A;
    localparam logic [5:0] IDX_CLKSEL_A      = 6'h01;
    localparam logic [5:0] IDX_CLKSEL_B      = 6'h09;
    localparam logic [5:0] IDX_IRQ_MASK      = 6'h10;
    localparam logic [5:0] IDX_DIV2_SET      = 6'h2E;
    localparam logic [5:0] IDX_DIV2_CLR      = 6'h2F;
    localparam logic [5:0] IDX_CT_STATE      = 6'h11;
    // Field positions
    localparam int AUX_MODE_HI   = 6;
    localparam int AUX_MODE_LO   = 4;
    localparam int ISR_READY_BIT = 3;
    localparam int CMD_CODE_HI   = 7;
    localparam int CMD_CODE_LO   = 4;
    localparam int CSR_RX_HI     = 7;
    localparam int CSR_RX_LO     = 4;
    localparam int CSR_TX_HI     = 3;
    localparam int CSR_TX_LO     = 0;
    // Encodings
    localparam logic [3:0] CMD_TIMEOUT_ON  = 4'hA;
    localparam logic [3:0] CMD_TIMEOUT_OFF = 4'hC;
    localparam logic [3:0] CSR_SEL_CT      = 4'hD;
    localparam logic [2:0] SRC_TIMER_BIT   = 3'h4;
    // Reset values
    localparam logic [7:0]  AUX_RESET     = 8'h00;
    localparam logic [7:0]  MASK_RESET    = 8'h00;
    localparam logic [15:0] PRELOAD_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    typedef enum logic [1:0] {
        BCT_IDLE    = 2'b00,
        BCT_RUN     = 2'b01,
        BCT_RELOAD  = 2'b11,
        BCT_EXPIRED = 2'b10
    } bct_state_t;
endpackage : bct_pkg

// ---- src/bct_prescale.sv ----
`timescale 1ns/1ps
// Counter clock enable from source select and optional halving
module bct_prescale (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Control
    input  wire logic       i_div2,
    input  wire logic [2:0] i_src,
    input  wire logic       i_ext_tick,
    // Tick out
    output logic            o_tick
);
    logic half_q;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            half_q <= 1'b0;
        end else begin
            half_q <= ~half_q;
        end
    end

    // Source code 3'b100 takes external pulse, others the core clock
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_tick <= 1'b0;
        end else if (i_src[1:0] == 2'b00 && i_src != 3'b000) begin
            o_tick <= i_ext_tick;
        end else begin
            o_tick <= i_div2 ? half_q : 1'b1;
        end
    end
endmodule : bct_prescale

// ---- src/bct_counter_timer.sv ----
`timescale 1ns/1ps
//Contract
// - 16-bit divider from preload registers
// - Timer, counter and timeout modes
// - Source and mode from aux bits 6:4
// - Falling output sets ready flag
// - Start read loads preload, starts count
// - Stop read clears ready bit 3
// - Timer half period equals divisor
// - Timer keeps running after stop
// - Counter source forces 16x sampling
// - Counter counts to zero, falls, wraps
// - Counter mode reads live count
// - Timeout mode ignores start and stop
// - Character load stops, reloads, restarts
// - Expiry sets ready, masked interrupt
// - Late character clears ready flag
// - Ax enables, Cx disables timeout
// - Ax clears flag, holds counter stopped
// - Restart on OR of both loads
// - Output drives rate clock and pins
// - Halved clock feeds counter when chosen
module bct_counter_timer #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST_N,
    // APB slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic [31:0]      O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Channel events
    input  wire logic        I_RX_LOAD_A,
    input  wire logic        I_RX_LOAD_B,
    input  wire logic        I_EXT_TICK,
    // Outputs
    output logic             O_CT_OUT,
    output logic             O_CT_GPIO,
    output logic             O_IRQ,
    output logic             O_RX16X_A,
    output logic             O_TX16X_A,
    output logic             O_RX16X_B,
    output logic             O_TX16X_B
);
    initial begin
        if (CNT_W != 16) $error("bct_counter_timer supports CNT_W of 16 only");
    end

    logic [7:0]             aux_q;
    logic [7:0]             mask_q;
    logic [CNT_W-1:0]       pre_q;
    logic [CNT_W-1:0]       cnt_q;
    logic [7:0]             csr_a_q;
    logic [7:0]             csr_b_q;
    logic                   div2_q;
    logic                   to_a_q;
    logic                   to_b_q;
    logic                   out_q;
    logic                   out_prev_q;
    logic                   ready_q;
    logic                   pend_q;
    bct_pkg::bct_state_t    st_q;
    logic                   tick;

    // APB decode
    logic [5:0] idx;
    logic       acc;
    logic       wr;
    logic       rd;
    logic       timeout_on;
    logic       timer_mode;
    logic       rx_load;
    logic       start_cmd;
    logic       stop_cmd;
    logic       cmd_on;
    logic       cmd_off_a;
    logic       cmd_off_b;
    logic       cmd_on_a;
    logic       cmd_on_b;
    logic       fall;

    function automatic logic is_cmd(input logic [31:0] d, input logic [3:0] code);
        is_cmd = (d[bct_pkg::CMD_CODE_HI:bct_pkg::CMD_CODE_LO] == code);
    endfunction : is_cmd

    assign idx        = I_PADDR[7:2];
    assign acc        = I_PSEL && I_PENABLE;
    assign wr         = acc && I_PWRITE;
    assign rd         = acc && !I_PWRITE;
    assign timeout_on = to_a_q || to_b_q;
    assign timer_mode = aux_q[bct_pkg::AUX_MODE_HI] || timeout_on;
    assign rx_load    = (to_a_q && I_RX_LOAD_A) || (to_b_q && I_RX_LOAD_B);
    assign start_cmd  = rd && idx == bct_pkg::IDX_START && !timeout_on;
    assign stop_cmd   = rd && idx == bct_pkg::IDX_STOP && !timeout_on;
    assign cmd_on_a   = wr && idx == bct_pkg::IDX_CMD_A && is_cmd(I_PWDATA, bct_pkg::CMD_TIMEOUT_ON);
    assign cmd_on_b   = wr && idx == bct_pkg::IDX_CMD_B && is_cmd(I_PWDATA, bct_pkg::CMD_TIMEOUT_ON);
    assign cmd_off_a  = wr && idx == bct_pkg::IDX_CMD_A && is_cmd(I_PWDATA, bct_pkg::CMD_TIMEOUT_OFF);
    assign cmd_off_b  = wr && idx == bct_pkg::IDX_CMD_B && is_cmd(I_PWDATA, bct_pkg::CMD_TIMEOUT_OFF);
    assign cmd_on     = cmd_on_a || cmd_on_b;
    assign fall       = out_prev_q && !out_q;

    bct_prescale u_prescale (
        .i_clk      (I_CLK),
        .i_rst_n    (I_RST_N),
        .i_div2     (div2_q),
        .i_src      (aux_q[bct_pkg::AUX_MODE_HI:bct_pkg::AUX_MODE_LO]),
        .i_ext_tick (I_EXT_TICK),
        .o_tick     (tick)
    );

    // Configuration registers
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            aux_q   <= bct_pkg::AUX_RESET;
            mask_q  <= bct_pkg::MASK_RESET;
            pre_q   <= bct_pkg::PRELOAD_RESET;
            csr_a_q <= 8'h00;
            csr_b_q <= 8'h00;
            div2_q  <= 1'b0;
        end else if (wr) begin
            case (idx)
                bct_pkg::IDX_AUX_CONTROL:  aux_q <= I_PWDATA[7:0];
                bct_pkg::IDX_IRQ_MASK:     mask_q <= I_PWDATA[7:0];
                bct_pkg::IDX_PRELOAD_HIGH: pre_q[15:8] <= I_PWDATA[7:0];
                bct_pkg::IDX_PRELOAD_LOW:  pre_q[7:0] <= I_PWDATA[7:0];
                bct_pkg::IDX_CLKSEL_A:     csr_a_q <= I_PWDATA[7:0];
                bct_pkg::IDX_CLKSEL_B:     csr_b_q <= I_PWDATA[7:0];
                bct_pkg::IDX_DIV2_SET:     div2_q <= 1'b1;
                bct_pkg::IDX_DIV2_CLR:     div2_q <= 1'b0;
                default:                   div2_q <= div2_q;
            endcase
        end
    end

    // Timeout enables per channel
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            to_a_q <= 1'b0;
            to_b_q <= 1'b0;
        end else begin
            if (cmd_on_a) to_a_q <= 1'b1;
            else if (cmd_off_a) to_a_q <= 1'b0;
            if (cmd_on_b) to_b_q <= 1'b1;
            else if (cmd_off_b) to_b_q <= 1'b0;
        end
    end

    // Pending character load held until next counter tick
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            pend_q <= 1'b0;
        end else if (rx_load) begin
            pend_q <= 1'b1;
        end else if (tick) begin
            pend_q <= 1'b0;
        end
    end

    // Counter state machine
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            st_q  <= bct_pkg::BCT_IDLE;
            cnt_q <= bct_pkg::COUNT_MAX;
            out_q <= 1'b1;
        end else if (cmd_on) begin
            st_q  <= bct_pkg::BCT_IDLE;
            out_q <= 1'b1;
        end else if (start_cmd) begin
            st_q  <= bct_pkg::BCT_RUN;
            cnt_q <= pre_q;
            out_q <= 1'b1;
        end else if (timeout_on && pend_q && tick) begin
            st_q <= bct_pkg::BCT_RELOAD;
        end else if (tick) begin
            case (st_q)
                bct_pkg::BCT_RELOAD: begin
                    cnt_q <= pre_q;
                    out_q <= 1'b1;
                    st_q  <= bct_pkg::BCT_RUN;
                end
                bct_pkg::BCT_RUN: begin
                    if (cnt_q == '0 || cnt_q == 16'h0001) begin
                        if (timer_mode && !timeout_on) begin
                            cnt_q <= pre_q;
                            out_q <= ~out_q;
                        end else begin
                            cnt_q <= cnt_q - 16'h0001;
                            out_q <= 1'b0;
                            st_q  <= bct_pkg::BCT_EXPIRED;
                        end
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                bct_pkg::BCT_EXPIRED: begin
                    if (!timeout_on) cnt_q <= cnt_q - 16'h0001;
                end
                default: st_q <= bct_pkg::BCT_IDLE;
            endcase
        end
    end

    // Ready flag: set wins over clear
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            out_prev_q <= 1'b1;
            ready_q    <= 1'b0;
        end else begin
            out_prev_q <= out_q;
            if (fall) ready_q <= 1'b1;
            else if (stop_cmd || cmd_on || rx_load) ready_q <= 1'b0;
        end
    end

    // Outputs
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_CT_OUT  <= 1'b1;
            O_CT_GPIO <= 1'b1;
            O_IRQ     <= 1'b0;
            O_RX16X_A <= 1'b0;
            O_TX16X_A <= 1'b0;
            O_RX16X_B <= 1'b0;
            O_TX16X_B <= 1'b0;
        end else begin
            O_CT_OUT  <= out_q;
            O_CT_GPIO <= out_q;
            O_IRQ     <= ready_q && mask_q[bct_pkg::ISR_READY_BIT];
            O_RX16X_A <= csr_a_q[bct_pkg::CSR_RX_HI:bct_pkg::CSR_RX_LO] == bct_pkg::CSR_SEL_CT;
            O_TX16X_A <= csr_a_q[bct_pkg::CSR_TX_HI:bct_pkg::CSR_TX_LO] == bct_pkg::CSR_SEL_CT;
            O_RX16X_B <= csr_b_q[bct_pkg::CSR_RX_HI:bct_pkg::CSR_RX_LO] == bct_pkg::CSR_SEL_CT;
            O_TX16X_B <= csr_b_q[bct_pkg::CSR_TX_HI:bct_pkg::CSR_TX_LO] == bct_pkg::CSR_SEL_CT;
        end
    end

    // APB read data, no wait states
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_PREADY  <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA  <= bct_pkg::UNMAPPED_DATA;
        end else begin
            O_PREADY  <= I_PSEL && !I_PENABLE;
            O_PSLVERR <= 1'b0;
            if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
                case (idx)
                    bct_pkg::IDX_AUX_CONTROL:  O_PRDATA <= {24'h0, aux_q};
                    bct_pkg::IDX_IRQ_STATUS:   O_PRDATA <= {28'h0, ready_q, 3'h0};
                    bct_pkg::IDX_PRELOAD_HIGH: O_PRDATA <= {24'h0, cnt_q[15:8]};
                    bct_pkg::IDX_PRELOAD_LOW:  O_PRDATA <= {24'h0, cnt_q[7:0]};
                    bct_pkg::IDX_IRQ_MASK:     O_PRDATA <= {24'h0, mask_q};
                    bct_pkg::IDX_CT_STATE:     O_PRDATA <= {27'h0, div2_q, to_b_q, to_a_q, st_q};
                    default:                   O_PRDATA <= bct_pkg::UNMAPPED_DATA;
                endcase
            end
        end
    end

    ready_set_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        fall |=> ready_q) else $error("ready not set after falling output");
    stop_clear_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        stop_cmd && !fall |=> !ready_q) else $error("stop did not clear ready");
    start_load_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        start_cmd && !cmd_on |=> cnt_q == $past(pre_q)) else $error("start did not load");
    ignore_cmd_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        timeout_on |-> !start_cmd && !stop_cmd) else $error("start or stop acted in timeout");
    arm_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        cmd_on && !fall |=> st_q == bct_pkg::BCT_IDLE && !ready_q) else $error("arm not held");
    irq_mask_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        ready_q && mask_q[3] |=> O_IRQ) else $error("irq not raised");
    sequence load_seq;
        timeout_on && pend_q && tick && !cmd_on;
    endsequence
    reload_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        load_seq |=> st_q == bct_pkg::BCT_RELOAD) else $error("no reload after load");
    sticky_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        ready_q && !stop_cmd && !cmd_on && !rx_load |=> ready_q) else $error("ready dropped");
endmodule : bct_counter_timer

// ---- test/bct_host.sv ----
`timescale 1ns/1ps
// Host processor driving the register bus
module bct_host (
    // Bus clock
    input  wire logic        i_clk,
    // Slave answer
    input  wire logic [31:0] i_prdata,
    input  wire logic        i_pready,
    // Master request
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic [7:0]       o_paddr,
    output logic [31:0]      o_pwdata
);
    initial begin
        o_psel    = 1'b0;
        o_penable = 1'b0;
        o_pwrite  = 1'b0;
        o_paddr   = 8'h00;
        o_pwdata  = 32'h0000_0000;
    end

    // One transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [5:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge i_clk);
        o_psel   <= 1'b1;
        o_pwrite <= w;
        o_paddr  <= {idx, 2'b00};
        o_pwdata <= wd;
        @(posedge i_clk);
        o_penable <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (i_pready !== 1'b1);
        rd = i_prdata;
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
        o_pwdata  <= ~wd;
    endtask : xfer

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, idx, d, x);
    endtask : wr

    // Count values are only trusted outside timer mode by the caller
    task automatic rd(input logic [5:0] idx, output logic [31:0] d);
        xfer(1'b0, idx, 32'h0000_0000, d);
    endtask : rd
endmodule : bct_host

// ---- test/block_counter_timer_rx_timeout_test.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module block_counter_timer_rx_timeout_test;
    logic        clk, rst_n, psel, penable, pwrite, rx_a, rx_b, ext_tick;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, d;
    logic        pready, pslverr, ct_out, gpio, irq, rxa, txa, rxb, txb;
    int          n_errors, samples_checked, n, h;

    bct_counter_timer i_bct_counter_timer (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RX_LOAD_A(rx_a),
        .I_RX_LOAD_B(rx_b), .I_EXT_TICK(ext_tick), .O_CT_OUT(ct_out), .O_CT_GPIO(gpio),
        .O_IRQ(irq), .O_RX16X_A(rxa), .O_TX16X_A(txa), .O_RX16X_B(rxb), .O_TX16X_B(txb));
    bct_host i_bct_host (.i_clk(clk), .i_prdata(prdata), .i_pready(pready), .o_psel(psel),
        .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));

    always #5 clk = ~clk;
    always @(posedge clk) ext_tick <= 1'($urandom % 2);

    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    task automatic ready_flag(output logic r);
        i_bct_host.rd(bct_pkg::IDX_IRQ_STATUS, d);
        r = d[bct_pkg::ISR_READY_BIT];
    endtask : ready_flag

    task automatic pulse(input logic b);
        if (b)
            rx_b <= 1'b1;
        else
            rx_a <= 1'b1;
        @(posedge clk);
        rx_a <= 1'b0;
        rx_b <= 1'b0;
    endtask : pulse

    // Cycles between two output transitions
    task automatic half_period(output int c);
        logic l;
        l = ct_out;
        for (int k = 0; k < 3000 && ct_out === l; k++) @(posedge clk);
        l = ct_out;
        for (c = 0; c < 3000 && ct_out === l; c++) @(posedge clk);
    endtask : half_period

    initial begin
        logic r;
        clk = 1'b0; rst_n = 1'b0; rx_a = 1'b0; rx_b = 1'b0; ext_tick = 1'b0;
        n_errors = 0; samples_checked = 0;
        void'($urandom(32'hef49));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK("ct_out idle", 1'b1, ct_out)
        i_bct_host.wr(bct_pkg::IDX_CLKSEL_A, 32'h0000_00D0);
        i_bct_host.wr(bct_pkg::IDX_CLKSEL_B, 32'h0000_000D);
        repeat (2) @(posedge clk);
        `CHK("16x", 4'b1001, {rxa, txa, rxb, txb})
        i_bct_host.rd(6'h3F, d);
        `CHK("unmapped", 32'h0000_0000, d)
        `CHK("pslverr", 1'b0, pslverr)
        // Counter mode, core clock, one shot
        i_bct_host.wr(bct_pkg::IDX_IRQ_MASK, 32'h0000_0008);
        i_bct_host.wr(bct_pkg::IDX_AUX_CONTROL, 32'h0000_0020);
        i_bct_host.wr(bct_pkg::IDX_PRELOAD_HIGH, 32'h0000_0012);
        i_bct_host.wr(bct_pkg::IDX_PRELOAD_LOW, 32'h0000_0034);
        i_bct_host.rd(bct_pkg::IDX_START, d);
        i_bct_host.rd(bct_pkg::IDX_PRELOAD_HIGH, d);
        `CHK("live count high", 32'h0000_0012, d)
        for (int k = 0; k < 6000 && ct_out === 1'b1; k++) @(posedge clk);
        `CHK("counter falls", 1'b0, ct_out)
        ready_flag(r);
        `CHK("ready after fall", 1'b1, r)
        ready_flag(r);
        `CHK("ready sticky", 1'b1, r)
        `CHK("irq masked in", 1'b1, irq)
        i_bct_host.rd(bct_pkg::IDX_STOP, d);
        ready_flag(r);
        `CHK("stop clears", 1'b0, r)
        `CHK("irq cleared", 1'b0, irq)
        // Timer mode, core clock, random divisors
        i_bct_host.wr(bct_pkg::IDX_AUX_CONTROL, 32'h0000_0060);
        for (int i = 0; i < 3; i++) begin
            n = 2 + int'($urandom % 30);
            i_bct_host.wr(bct_pkg::IDX_PRELOAD_HIGH, 32'h0000_0000);
            i_bct_host.wr(bct_pkg::IDX_PRELOAD_LOW, 32'(n));
            i_bct_host.rd(bct_pkg::IDX_START, d);
            half_period(h);
            `CHK("half period", n, h)
            half_period(h);
            `CHK("next half", n, h)
            `CHK("gpio copy", ct_out, gpio)
        end
        i_bct_host.rd(bct_pkg::IDX_STOP, d);
        repeat (2 * n + 4) @(posedge clk);
        ready_flag(r);
        `CHK("timer after stop", 1'b1, r)
        i_bct_host.wr(bct_pkg::IDX_DIV2_SET, 32'h0000_0000);
        half_period(h);
        half_period(h);
        `CHK("halved clock", 2 * n, h)
        i_bct_host.wr(bct_pkg::IDX_DIV2_CLR, 32'h0000_0000);
        // Timeout mode on channel a
        i_bct_host.wr(bct_pkg::IDX_AUX_CONTROL, 32'h0000_0020);
        i_bct_host.wr(bct_pkg::IDX_PRELOAD_LOW, 32'h0000_0028);
        // Let the running count expire before arming, so its fall cannot meet the command
        repeat (40) @(posedge clk);
        i_bct_host.wr(bct_pkg::IDX_CMD_A, 32'h0000_00A0);
        repeat (100) @(posedge clk);
        ready_flag(r);
        `CHK("held stopped", 1'b0, r)
        pulse(1'b0);
        repeat (60) @(posedge clk);
        ready_flag(r);
        `CHK("idle expiry", 1'b1, r)
        `CHK("idle irq", 1'b1, irq)
        i_bct_host.rd(bct_pkg::IDX_STOP, d);
        ready_flag(r);
        `CHK("stop ignored", 1'b1, r)
        pulse(1'b0);
        ready_flag(r);
        `CHK("late char", 1'b0, r)
        // Both receivers on; channel b alone restarts
        i_bct_host.wr(bct_pkg::IDX_CMD_B, 32'h0000_00A0);
        pulse(1'b0);
        repeat (60) @(posedge clk);
        pulse(1'b1);
        ready_flag(r);
        `CHK("either restarts", 1'b0, r)
        i_bct_host.wr(bct_pkg::IDX_CMD_A, 32'h0000_00C0);
        i_bct_host.wr(bct_pkg::IDX_CMD_B, 32'h0000_00C0);
        repeat (60) @(posedge clk);
        i_bct_host.rd(bct_pkg::IDX_STOP, d);
        ready_flag(r);
        `CHK("timeout off", 1'b0, r)
        conclude();
    end

    initial begin
        #400_000;
        n_errors++;
        conclude();
    end
endmodule : block_counter_timer_rx_timeout_test
